// >>> cds_consts.svh
// Offsets, field positions, reset values and timing counts of the doze and sleep control.
`ifndef CDS_CONSTS_SVH
`define CDS_CONSTS_SVH

// ============================================================================
// Register byte offsets
`define CDS_OFS_CONTROL     4'h0
`define CDS_OFS_STATUS      4'h4

// ============================================================================
// Control register fields
`define CDS_CTL_HALT_BIT    7
`define CDS_CTL_SLOW_BIT    6
`define CDS_CTL_FAST_BIT    5
`define CDS_CTL_RET_BIT     4
`define CDS_CTL_RATIO_HI    2
`define CDS_CTL_RATIO_LO    0

// ============================================================================
// Status register fields
`define CDS_STA_TMO_BIT     0
`define CDS_STA_PWD_BIT     1
`define CDS_STA_SLEEP_BIT   2
`define CDS_STA_IDLE_BIT    3
`define CDS_STA_WAIT_BIT    4

// ============================================================================
// Reset values and timing
`define CDS_RST_RATIO       3'h0
`define CDS_RST_FLAG_N      1'h1
`define CDS_PHASE_LAST      2'h3

`endif

// >>> cds_pkg.sv
// Types shared by the doze and sleep control.
package cds_pkg;

  // ==========================================================================
  // Power state of the core
  typedef enum logic [1:0] {
    RUN,
    IDLE,
    SLEEP,
    WAKE_WAIT
  } cds_state_e;

  // ==========================================================================
  // Software-visible slowdown control fields
  typedef struct packed {
    logic       haltSelect;
    logic       slowdownActive;
    logic       fastOnInterrupt;
    logic       slowAfterReturn;
    logic [2:0] ratio;
  } cds_ctrl_s;

endpackage

// >>> cds_doze_sleep.sv
// Doze, idle and sleep control of the CPU core with an Avalon-MM register slave.
//
// Overview of operation
// R1: Doze lets CPU run one cycle in N.
// R2: Ratio code 0 gives 1:2, doubling to 1:256.
// R3: System clock and quarter clock keep running in doze.
// R4: ISR entry copies doze state to slow-after-return.
// R5: ISR entry clears doze when fast-on-interrupt set.
// R6: ISR return loads doze from slow-after-return.
// R7: Slow-after-return stays software writable inside ISR.
// R8: Multicycle instruction finishes before vector fetch.
// R9: Cancelled vectoring still clears doze, full speed.
// R10: Sleep instruction with halt-select clear gates CPU.
// R11: Sleep instruction with halt-select set enters idle.
// R12: Sleep entry clears watchdog; sleep-enabled watchdog counts.
// R13: Sleep entry clears power-down, sets timeout flag.
// R14: Low, secondary, high and converter oscillators stay on.
// R15: Ports hold their pre-sleep state during sleep.
// R16: Sleep alters no reset source except watchdog.
// R17: Enabled reset sources leave sleep by full reset.
// R18: All interrupts but clock-switch wake without reset.
// R19: Own enable needed; global enable not needed.
// R20: After wake, ISR called only with global enable.
// R21: Every wake from sleep clears the watchdog.
// R22: Wake waits for flash, oscillator and brown-out ready.
// R23: Interrupt pending before sleep makes it a no-op.
// R24: Interrupt during sleep instruction: sleep, wake at once.
// R25: Free counter of instruction cycles gates CPU enable.
// R26: Wake restores the doze or normal state before sleep.
//
// Implementation choices: the register offsets and the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none
`include "cds_consts.svh"

module cds_doze_sleep #(
  parameter int NUM_IRQ    = 16,
  parameter int CSW_INDEX  = 3,
  parameter int RATIO_BITS = 8
) (
  // Clock and reset
  input  wire logic                  sys_clk,
  input  wire logic                  nrst,
  // Avalon-MM register slave
  input  wire logic [3:0]            address,
  input  wire logic                  read,
  input  wire logic                  write,
  input  wire logic [3:0]            byteenable,
  input  wire logic [31:0]           writedata,
  output logic      [31:0]           readdata,
  output logic                       waitrequest,
  // CPU core events
  input  wire logic                  sleepExec,
  input  wire logic                  isrEntry,
  input  wire logic                  isrReturn,
  input  wire logic                  vectorCancel,
  input  wire logic                  instrBusy,
  input  wire logic                  vectorReq,
  output logic                       vectorGrant,
  output logic                       cpuClkEn,
  output logic                       periphCycleTick,
  output logic                       wakeResume,
  output logic                       wakeCallIsr,
  // Interrupt controller
  input  wire logic [NUM_IRQ-1:0]    irqFlag,
  input  wire logic [NUM_IRQ-1:0]    irqEnable,
  input  wire logic                  globalIrqEnable,
  // Watchdog
  input  wire logic                  wdtSleepEnable,
  input  wire logic                  wdtWake,
  output logic                       wdtClear,
  output logic                       wdtCountEn,
  // Reset sources and readiness
  input  wire logic [4:0]            resetSource,
  input  wire logic                  flashReady,
  input  wire logic                  oscReady,
  input  wire logic                  brownoutReady,
  input  wire logic                  brownoutDisabled,
  output logic                       deviceResetReq,
  // Clocks and pins
  output logic [3:0]                 oscKeepOn,
  output logic                       ioHold,
  output logic                       powerdownFlagN,
  output logic                       timeoutFlagN
);

  // ==========================================================================
  // State
  cds_pkg::cds_state_e   state_ff;
  cds_pkg::cds_state_e   nxt_state;
  cds_pkg::cds_ctrl_s    ctrl_ff;
  logic [1:0]            phase_ff;
  logic [RATIO_BITS-1:0] dozeCnt_ff;
  logic [RATIO_BITS-1:0] ratioMask;
  logic                  ackFf_ff;
  logic [31:0]           readdata_ff;
  logic                  pwdN_ff;
  logic                  tmoN_ff;
  logic                  wdtClear_ff;
  logic                  wakeResume_ff;
  logic                  wakeCallIsr_ff;
  logic                  resetReq_ff;
  logic                  wakeIrq;
  logic                  sleepEnter;
  logic                  wakeReady;
  logic                  regWrite;
  logic                  instrTick;
  logic [NUM_IRQ-1:0]    wakeMask;

  // ==========================================================================
  // Wake sources
  always_comb begin
    wakeMask            = '1;
    wakeMask[CSW_INDEX] = 1'b0;
  end
  assign wakeIrq    = |(irqFlag & irqEnable & wakeMask); // see R18 see R19
  // An enabled flag other than clock-switch already pending at a sleep instruction with halt-select clear turns it into a no-op.
  assign sleepEnter = (state_ff == cds_pkg::RUN) && sleepExec && !ctrl_ff.haltSelect
                      && !wakeIrq; // see R10 see R23
  assign wakeReady  = flashReady && oscReady
                      && (brownoutReady || brownoutDisabled); // see R22

  // ==========================================================================
  // Power state machine
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      cds_pkg::RUN: begin
        if (sleepExec && ctrl_ff.haltSelect) begin
          nxt_state = cds_pkg::IDLE; // see R11
        end else if (sleepEnter) begin
          nxt_state = cds_pkg::SLEEP; // see R10
        end
      end
      cds_pkg::IDLE: begin
        if (wakeIrq || wdtWake) begin
          nxt_state = cds_pkg::RUN;
        end
      end
      cds_pkg::SLEEP: begin
        // An interrupt raised while asleep starts the wake on the next edge.
        if (wakeIrq) begin
          nxt_state = cds_pkg::WAKE_WAIT; // see R18 see R24
        end
      end
      cds_pkg::WAKE_WAIT: begin
        if (wakeReady) begin
          nxt_state = cds_pkg::RUN; // see R22
        end
      end
      default: begin
        nxt_state = cds_pkg::RUN;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      state_ff <= cds_pkg::RUN;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ==========================================================================
  // Status flags: set on sleep entry only, untouched by a no-op sleep
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      pwdN_ff <= `CDS_RST_FLAG_N;
      tmoN_ff <= `CDS_RST_FLAG_N;
    end else if (sleepEnter) begin
      pwdN_ff <= 1'b0; // see R13 see R24
      tmoN_ff <= 1'b1; // see R13
    end
  end

  // ==========================================================================
  // Watchdog clear and wake pulses
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      wdtClear_ff    <= 1'b0;
      wakeResume_ff  <= 1'b0;
      wakeCallIsr_ff <= 1'b0;
    end else begin
      // Clears counter and prescaler on sleep entry and on every wake from sleep.
      wdtClear_ff    <= sleepEnter // see R12 see R24
                        || (state_ff == cds_pkg::SLEEP && nxt_state != cds_pkg::SLEEP); // see R21
      wakeResume_ff  <= (state_ff == cds_pkg::WAKE_WAIT) && wakeReady;
      wakeCallIsr_ff <= (state_ff == cds_pkg::WAKE_WAIT) && wakeReady
                        && globalIrqEnable; // see R20
    end
  end

  // Reset sources are passed on unchanged in every state; sleep never masks them.
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      resetReq_ff <= 1'b0;
    end else begin
      resetReq_ff <= |resetSource; // see R16 see R17
    end
  end

  // ==========================================================================
  // Instruction-cycle phase and doze counter
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      phase_ff <= 2'h0;
    end else begin
      phase_ff <= phase_ff + 2'h1; // see R3
    end
  end
  assign instrTick = (phase_ff == `CDS_PHASE_LAST);
  // Code k selects a period of 2^(k+1) instruction cycles.
  assign ratioMask = RATIO_BITS'((2 << ctrl_ff.ratio) - 1); // see R2

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      dozeCnt_ff <= '0;
    end else if (instrTick) begin
      dozeCnt_ff <= (dozeCnt_ff + 1'b1) & ratioMask; // see R25
    end
  end

  // ==========================================================================
  // Slowdown control register: hardware events win over a software write
  assign regWrite = write && ackFf_ff && (address == `CDS_OFS_CONTROL) && byteenable[0];

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_ff <= '{1'b0, 1'b0, 1'b0, 1'b0, `CDS_RST_RATIO};
    end else begin
      if (regWrite) begin
        ctrl_ff.haltSelect      <= writedata[`CDS_CTL_HALT_BIT];
        ctrl_ff.slowdownActive  <= writedata[`CDS_CTL_SLOW_BIT];
        ctrl_ff.fastOnInterrupt <= writedata[`CDS_CTL_FAST_BIT];
        ctrl_ff.slowAfterReturn <= writedata[`CDS_CTL_RET_BIT]; // see R7
        ctrl_ff.ratio           <= writedata[`CDS_CTL_RATIO_HI:`CDS_CTL_RATIO_LO];
      end
      if (isrEntry) begin
        ctrl_ff.slowAfterReturn <= ctrl_ff.slowdownActive; // see R4
        if (ctrl_ff.fastOnInterrupt) begin
          ctrl_ff.slowdownActive <= 1'b0; // see R5
        end
      end
      if (vectorCancel) begin
        ctrl_ff.slowdownActive <= 1'b0; // see R9
      end
      if (isrReturn) begin
        ctrl_ff.slowdownActive <= ctrl_ff.slowAfterReturn; // see R6
      end
    end
  end

  // ==========================================================================
  // Avalon-MM slave: one wait cycle, then data and write commit together
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      ackFf_ff    <= 1'b0;
      readdata_ff <= 32'h0000_0000;
    end else begin
      ackFf_ff <= (read || write) && !ackFf_ff;
      if (read && !ackFf_ff) begin
        readdata_ff <= 32'h0000_0000;
        case (address)
          `CDS_OFS_CONTROL: begin
            readdata_ff[7:0] <= {ctrl_ff[6:3], 1'b0, ctrl_ff.ratio};
          end
          `CDS_OFS_STATUS: begin
            readdata_ff[`CDS_STA_TMO_BIT]   <= tmoN_ff;
            readdata_ff[`CDS_STA_PWD_BIT]   <= pwdN_ff;
            readdata_ff[`CDS_STA_SLEEP_BIT] <= (state_ff == cds_pkg::SLEEP);
            readdata_ff[`CDS_STA_IDLE_BIT]  <= (state_ff == cds_pkg::IDLE);
            readdata_ff[`CDS_STA_WAIT_BIT]  <= (state_ff == cds_pkg::WAKE_WAIT);
          end
          default: begin
            readdata_ff <= 32'h0000_0000;
          end
        endcase
      end
    end
  end
  assign waitrequest = (read || write) && !ackFf_ff;
  assign readdata    = readdata_ff;

  // ==========================================================================
  // Outputs
  // The slowdown bit is never touched by sleep, so the wake returns to it.
  assign cpuClkEn        = (state_ff == cds_pkg::RUN)
                           && (!ctrl_ff.slowdownActive || dozeCnt_ff == '0); // see R1 see R26
  // Grant only on an enabled CPU cycle with no multicycle instruction open.
  assign vectorGrant     = vectorReq && !instrBusy && cpuClkEn; // see R8
  assign periphCycleTick = instrTick; // see R3
  assign wakeResume      = wakeResume_ff;
  assign wakeCallIsr     = wakeCallIsr_ff;
  assign wdtClear        = wdtClear_ff;
  assign wdtCountEn      = (state_ff != cds_pkg::SLEEP) || wdtSleepEnable; // see R12
  assign deviceResetReq  = resetReq_ff;
  assign oscKeepOn       = 4'hF; // see R14
  assign ioHold          = (state_ff == cds_pkg::SLEEP)
                           || (state_ff == cds_pkg::WAKE_WAIT); // see R15
  assign powerdownFlagN  = pwdN_ff;
  assign timeoutFlagN    = tmoN_ff;

endmodule
`default_nettype wire

// >>> cds_doze_sleep_assertions.sv
// Port-level checks of the doze and sleep control.
`timescale 1ns/1ps
`default_nettype none
module cds_doze_sleep_chk (
  // Clock and reset
  input wire logic       sys_clk,
  input wire logic       nrst,
  // Watched ports
  input wire logic       instrBusy,
  input wire logic       vectorReq,
  input wire logic       vectorGrant,
  input wire logic       cpuClkEn,
  input wire logic       periphCycleTick,
  input wire logic       wakeResume,
  input wire logic       wakeCallIsr,
  input wire logic       flashReady,
  input wire logic       oscReady,
  input wire logic       brownoutReady,
  input wire logic       brownoutDisabled,
  input wire logic [4:0] resetSource,
  input wire logic       deviceResetReq,
  input wire logic       wdtClear,
  input wire logic [3:0] oscKeepOn,
  input wire logic       ioHold,
  input wire logic       powerdownFlagN,
  input wire logic       timeoutFlagN
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  // ==========================================================================
  // Checks
  chk_tick_period: assert property (periphCycleTick |=> !periphCycleTick [*3] ##1 periphCycleTick)
    else $error("tick period wrong");
  chk_osc_on: assert property (oscKeepOn == 4'hF)
    else $error("oscillator dropped");
  chk_reset_req: assert property (|resetSource |=> deviceResetReq)
    else $error("reset request missing");
  chk_grant_busy: assert property (vectorGrant |-> vectorReq && !instrBusy && cpuClkEn)
    else $error("grant during busy");
  chk_hold_gate: assert property (ioHold |-> !cpuClkEn)
    else $error("cpu runs while held");
  chk_wake_ready: assert property (wakeResume |->
      $past(flashReady && oscReady && (brownoutReady || brownoutDisabled)))
    else $error("wake before ready");
  chk_call_wake: assert property (wakeCallIsr |-> wakeResume)
    else $error("call without wake");
  chk_sleep_flags: assert property ($fell(powerdownFlagN) |-> timeoutFlagN && ioHold && wdtClear)
    else $error("sleep entry flags");
endmodule
bind cds_doze_sleep cds_doze_sleep_chk cds_doze_sleep_chk_inst (.sys_clk(sys_clk), .nrst(nrst),
  .instrBusy(instrBusy), .vectorReq(vectorReq), .vectorGrant(vectorGrant), .cpuClkEn(cpuClkEn),
  .periphCycleTick(periphCycleTick), .wakeResume(wakeResume), .wakeCallIsr(wakeCallIsr),
  .flashReady(flashReady), .oscReady(oscReady), .brownoutReady(brownoutReady),
  .brownoutDisabled(brownoutDisabled), .resetSource(resetSource),
  .deviceResetReq(deviceResetReq), .wdtClear(wdtClear), .oscKeepOn(oscKeepOn),
  .ioHold(ioHold), .powerdownFlagN(powerdownFlagN), .timeoutFlagN(timeoutFlagN));
`default_nettype wire

// >>> cds_core_model.sv
// Model of the flash, oscillator and brown-out readiness seen after a wake.
`timescale 1ns/1ps
`default_nettype none
module cds_core_model (
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic nrst,
  // From the control
  input  wire logic ioHold,
  input  wire logic wdtClear,
  // Readiness
  output logic      flashReady,
  output logic      oscReady,
  output logic      brownoutReady,
  output logic      brownoutDisabled
);
  logic [3:0] waitCnt_ff;
  // The wake clear restarts the settle count, so every wake sees a slow supply.
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) waitCnt_ff <= 4'h0;
    else if (!ioHold) waitCnt_ff <= 4'h0;
    else if (wdtClear) waitCnt_ff <= 4'h1;
    else if (waitCnt_ff != 4'hF) waitCnt_ff <= waitCnt_ff + 4'h1;
  end
  assign flashReady       = !(ioHold && (wdtClear || waitCnt_ff inside {[4'h1:4'h3]}));
  assign oscReady         = !(ioHold && (wdtClear || waitCnt_ff inside {[4'h1:4'h5]}));
  assign brownoutReady    = !(ioHold && (wdtClear || waitCnt_ff inside {[4'h1:4'h7]}));
  assign brownoutDisabled = 1'b0;
endmodule
`default_nettype wire

// >>> tb_cds_doze_sleep.sv
// Self-checking testbench of the doze and sleep control.
`timescale 1ns/1ps
`default_nettype none
module tb_cds_doze_sleep;
  logic        sys_clk, nrst, read, write, global_irq_enable, wdtSleepEnable, wdtWake, instrBusy, vectorReq;
  logic        waitrequest, cpuClkEn, wakeResume, wakeCallIsr, wdtClear, deviceResetReq, ioHold;
  logic        flashReady, oscReady, brownoutReady, brownoutDisabled, ok, c, w, s, f, r;
  logic        wdtCountEn;
  logic [3:0]  address, ev;
  logic [4:0]  resetSource;
  logic [15:0] irqFlag, irqEnable;
  logic [31:0] writedata, readdata, q;
  int          n_fail, tests_run, i, k, n;
  cds_doze_sleep cds_doze_sleep_inst (.sys_clk(sys_clk), .nrst(nrst), .address(address),
    .read(read), .write(write), .byteenable(4'hF), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .sleepExec(ev[3]), .isrEntry(ev[2]), .isrReturn(ev[1]),
    .vectorCancel(ev[0]), .instrBusy(instrBusy), .vectorReq(vectorReq), .vectorGrant(),
    .cpuClkEn(cpuClkEn), .periphCycleTick(), .wakeResume(wakeResume), .wakeCallIsr(wakeCallIsr),
    .irqFlag(irqFlag), .irqEnable(irqEnable), .globalIrqEnable(global_irq_enable),
    .wdtSleepEnable(wdtSleepEnable), .wdtWake(wdtWake), .wdtClear(wdtClear),
    .wdtCountEn(wdtCountEn),
    .resetSource(resetSource), .flashReady(flashReady), .oscReady(oscReady),
    .brownoutReady(brownoutReady), .brownoutDisabled(brownoutDisabled),
    .deviceResetReq(deviceResetReq), .oscKeepOn(), .ioHold(ioHold), .powerdownFlagN(),
    .timeoutFlagN());
  cds_core_model cds_core_model_inst (.sys_clk(sys_clk), .nrst(nrst), .ioHold(ioHold),
    .wdtClear(wdtClear), .flashReady(flashReady), .oscReady(oscReady),
    .brownoutReady(brownoutReady), .brownoutDisabled(brownoutDisabled));
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) if (nrst) {instrBusy, vectorReq, wdtSleepEnable} <= 3'($urandom);
  // ==========================================================================
  // Helpers
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop(input int extra);
    n_fail += extra;
    $display("counts: compares=%0d mismatches=%0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // Waitrequest and read data are read right at the rising edge, before that edge's updates
  // land; the request is held until the edge at which waitrequest is seen low.
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    address <= a;
    writedata <= d;
    write <= wr;
    read <= !wr;
    ok = 1'b0;
    for (i = 0; i < 20 && !ok; i++) begin
      @(posedge sys_clk);
      ok = (waitrequest === 1'b0);
      q = readdata;
    end
    read <= 1'b0;
    write <= 1'b0;
    @(posedge sys_clk);
    if (!ok) report_and_stop(1);
  endtask
  task automatic pulse(input logic [3:0] e);
    ev <= e;
    @(posedge sys_clk);
    ev <= 4'h0;
    @(posedge sys_clk);
  endtask
  function automatic logic [31:0] ctl(input logic sl, input logic fa, input logic re);
    return {25'h0, sl, fa, re, 4'h1};
  endfunction
  // ==========================================================================
  // Main sequence
  initial begin
    n_fail = 0; tests_run = 0; q = $urandom(32'hCBC3F2FA);
    nrst = 0; read = 0; write = 0; address = 0; writedata = 0; ev = 0; global_irq_enable = 0; wdtWake = 0;
    irqFlag = 0; irqEnable = 0; resetSource = 0; instrBusy = 0; vectorReq = 0;
    wdtSleepEnable = 0;
    repeat (8) @(posedge sys_clk);
    nrst <= 1'b1;
    @(posedge sys_clk);
    bus(0, 4'h0, 0); check(q, 32'h0);
    bus(0, 4'h4, 0); check(q, 32'h3);
    bus(1, 4'h8, 32'hFF); bus(0, 4'h8, 0); check(q, 32'h0);
    irqEnable <= 16'h1; irqFlag <= 16'h1;
    pulse(4'h8); bus(0, 4'h4, 0); check(q, 32'h3);
    irqFlag <= 16'h0; irqEnable <= 16'h0;
    $display("done: reset values and pending no-op");
    for (k = 0; k < 2; k++) begin
      pulse(4'h8); bus(0, 4'h4, 0); check(q, 32'h5);
      @(negedge sys_clk); check(wdtCountEn, wdtSleepEnable);
      @(posedge sys_clk);
      irqFlag <= 16'h000A; irqEnable <= 16'h0008; global_irq_enable <= k[0];
      repeat (4) @(posedge sys_clk);
      bus(0, 4'h4, 0); check(q, 32'h5);
      irqEnable <= 16'h000A; ok = 0; c = 0; w = 0;
      for (n = 0; n < 60 && !ok; n++) begin
        @(negedge sys_clk); ok = (wakeResume === 1'b1); c = wakeCallIsr; w |= wdtClear;
      end
      @(posedge sys_clk);
      check(ok, 1); check(n > 8, 1); check(w, 1); check(c, k[0]);
      irqFlag <= 16'h0; bus(0, 4'h4, 0); check(q, 32'h1);
      @(negedge sys_clk); check(cpuClkEn, 1); @(posedge sys_clk);
    end
    $display("done: sleep and wake");
    for (k = 0; k < 8; k++) begin
      bus(1, 4'h0, 32'h40 | k); n = 0;
      repeat (8 << (k + 1)) begin
        @(negedge sys_clk); n += int'(cpuClkEn === 1'b1);
      end
      @(posedge sys_clk); check(32'(n), 32'd8);
    end
    $display("done: doze ratios");
    for (k = 0; k < 8; k++) begin
      {s, f, r} = 3'($urandom);
      bus(1, 4'h0, ctl(s, f, 0)); pulse(4'h4);
      bus(0, 4'h0, 0); check(q, ctl(s & !f, f, s));
      bus(1, 4'h0, ctl(s & !f, f, r)); pulse(4'h2);
      bus(0, 4'h0, 0); check(q, ctl(r, f, r));
    end
    bus(1, 4'h0, 32'h41); pulse(4'h1); bus(0, 4'h0, 0); check(q, 32'h01);
    $display("done: interrupt doze handling");
    bus(1, 4'h0, 32'h80); pulse(4'h8); bus(0, 4'h4, 0); check(q, 32'h9);
    wdtWake <= 1'b1; @(posedge sys_clk); wdtWake <= 1'b0; @(posedge sys_clk);
    bus(0, 4'h4, 0); check(q, 32'h1);
    resetSource <= 5'h10; @(posedge sys_clk); resetSource <= 5'h0;
    @(negedge sys_clk); check(deviceResetReq, 1);
    $display("done: idle and reset request");
    @(posedge sys_clk);
    report_and_stop(0);
  end
endmodule
`default_nettype wire
